// *** verilog/bgac_pkg.sv ***
`default_nettype none
package bgac_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          DELAY_W     = 11;
  localparam int          LEVEL_W     = 16;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_DELAY   = 8'h04;
  localparam logic [7:0]  REG_CMD     = 8'h08;
  localparam logic [7:0]  REG_STATUS  = 8'h0C;
  localparam logic [7:0]  REG_DROOP   = 8'h10;
  localparam logic [7:0]  REG_COUNT   = 8'h14;
  // control fields
  localparam int          CTRL_SRC    = 0;
  localparam int          CTRL_CONT   = 1;
  // command fields
  localparam int          CMD_SEND    = 0;
  localparam int          CMD_STOP    = 1;
  localparam int          CMD_ARM     = 2;
  localparam int          CMD_DISARM  = 3;
  // status fields
  localparam int          ST_ARMED    = 0;
  localparam int          ST_MEAS     = 1;
  localparam int          ST_SHOWN    = 2;
  localparam int          ST_GEN_ON   = 3;
  localparam int          ST_GEN_WAIT = 4;
  localparam int          ST_SRC      = 5;
  // reset values and limits
  localparam logic [1:0]  CTRL_RST    = 2'h0;
  localparam logic [10:0] DELAY_RST   = 11'h000;
  localparam logic [10:0] DELAY_MAX   = 11'h797;
  localparam logic [8:0]  LFSR_SEED   = 9'h1FF;
  localparam int          MEAS_SYMS   = 162;

  typedef enum logic [1:0] {
    BGAC_G_IDLE,
    BGAC_G_FRAME,
    BGAC_G_DELAY,
    BGAC_G_SEND
  } bgac_gen_state_t;

  typedef enum logic [1:0] {
    BGAC_A_IDLE,
    BGAC_A_ARMED,
    BGAC_A_MEAS,
    BGAC_A_DONE
  } bgac_anl_state_t;
endpackage : bgac_pkg
`default_nettype wire

// *** verilog/bgac_gen_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bgac_gen_if;
  import bgac_pkg::*;
  logic               send;
  logic               stop;
  logic               halt;
  logic [DELAY_W-1:0] delay;
  logic               bit_tick;
  logic               frame_rise;
  logic               data;
  logic               valid;
  logic               active;
  logic               waiting;

  modport ctl (output send, stop, halt, delay, bit_tick, frame_rise,
               input data, valid, active, waiting);
  modport gen (input send, stop, halt, delay, bit_tick, frame_rise,
               output data, valid, active, waiting);
endinterface : bgac_gen_if
`default_nettype wire

// *** verilog/bgac_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module bgac_gen (
  input  wire logic core_clk,
  input  wire logic rst_b,
  bgac_gen_if.gen   gif
);
  import bgac_pkg::*;

  bgac_gen_state_t    state;
  logic [DELAY_W-1:0] dly_cnt;
  logic [8:0]         lfsr;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= BGAC_G_IDLE;
    end else if (gif.stop || gif.halt) begin
      state <= BGAC_G_IDLE;
    end else if (gif.send) begin
      // zero delay skips the frame wait entirely
      if (gif.delay == '0) begin
        state <= BGAC_G_SEND;
      end else begin
        state <= BGAC_G_FRAME;
      end
    end else begin
      case (state)
        BGAC_G_FRAME: begin
          if (gif.frame_rise) begin
            state <= BGAC_G_DELAY;
          end
        end
        BGAC_G_DELAY: begin
          if (gif.bit_tick && dly_cnt == gif.delay - 11'h001) begin
            state <= BGAC_G_SEND;
          end
        end
        default: state <= state;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_cnt <= '0;
    end else if (state != BGAC_G_DELAY) begin
      dly_cnt <= '0;
    end else if (gif.bit_tick) begin
      dly_cnt <= dly_cnt + 11'h001; // whole bits only
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr      <= LFSR_SEED;
      gif.data  <= 1'b0;
      gif.valid <= 1'b0;
    end else begin
      gif.valid <= (state == BGAC_G_SEND) && gif.bit_tick;
      if (state == BGAC_G_SEND && gif.bit_tick) begin
        lfsr     <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
        gif.data <= lfsr[8];
      end else if (state == BGAC_G_IDLE) begin
        lfsr     <= LFSR_SEED;
        gif.data <= 1'b0;
      end
    end
  end

  assign gif.active  = (state == BGAC_G_SEND);
  assign gif.waiting = (state == BGAC_G_FRAME) || (state == BGAC_G_DELAY);
endmodule : bgac_gen
`default_nettype wire

// *** verilog/bgac_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - one source feeds modulator, analyzer, rear output
// - internal select uses own generator
// - external select uses front external input
// - armed analyzer measures on trigger only
// - setting change aborts and re-arms analyzer
// - setting change halts generator output
// - single mode: one measurement per arming
// - continuous mode repeats, updating results
// - disarm only when armed or measuring, nothing shown
// - arm during measurement restarts armed
// - send starts at once if delay zero
// - delay counts bits from frame rise
// - stop ceases generator output data
// - droop is first-last level per symbol
module bgac_top #(
  parameter int MEAS_SYMS_P = bgac_pkg::MEAS_SYMS
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic [bgac_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [bgac_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [bgac_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        frame_clk,
  input  wire logic                        bit_tick,
  input  wire logic                        ext_bb_data,
  input  wire logic                        ext_bb_valid,
  input  wire logic                        anl_trigger,
  input  wire logic [bgac_pkg::LEVEL_W-1:0] sym_level,
  input  wire logic                        sym_valid,
  output var  logic                        mod_data,
  output var  logic                        mod_valid,
  output var  logic                        anl_data,
  output var  logic                        anl_data_valid,
  output var  logic                        baseband_data_output,
  output var  logic                        baseband_data_output_valid,
  output var  logic                        anl_armed,
  output var  logic                        anl_busy,
  output var  logic                        meas_done
);
  import bgac_pkg::*;

  localparam logic [15:0] SYMS_M1 = 16'(MEAS_SYMS_P - 1);

  bgac_gen_if gif ();

  // settings and commands
  logic               src_ext;
  logic               cont_mode;
  logic [DELAY_W-1:0] delay;
  logic [DELAY_W-1:0] next_delay;
  logic               wr_ctrl;
  logic               wr_delay;
  logic               wr_cmd;
  logic               setting_chg;
  logic               cmd_send;
  logic               cmd_stop;
  logic               cmd_arm;
  logic               cmd_disarm;
  logic               frame_q;

  // analyzer state
  bgac_anl_state_t        anl_state;
  logic                   shown;
  logic [15:0]            sym_cnt;
  logic [LEVEL_W-1:0]     first_lvl;
  logic signed [LEVEL_W:0] level_diff;
  logic signed [LEVEL_W-1:0] droop;
  logic [15:0]            meas_count;
  logic                   last_sym;
  logic                   disarm_ok;
  logic                   meas_end;
  logic [ST_SRC:0]        status;

  assign wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  assign wr_delay = reg_wr && (reg_addr == REG_DELAY);
  assign wr_cmd   = reg_wr && (reg_addr == REG_CMD);

  // out-of-range delay saturates rather than wrapping
  assign next_delay = (reg_wdata[DELAY_W-1:0] > DELAY_MAX ||
                       reg_wdata[DATA_W-1:DELAY_W] != '0)
                      ? DELAY_MAX : reg_wdata[DELAY_W-1:0];

  // only a real change of value counts; rewriting the same value is benign
  assign setting_chg =
    (wr_ctrl && (reg_wdata[CTRL_SRC] != src_ext ||
                 reg_wdata[CTRL_CONT] != cont_mode)) ||
    (wr_delay && next_delay != delay);

  assign cmd_send   = wr_cmd && reg_wdata[CMD_SEND];
  assign cmd_stop   = wr_cmd && reg_wdata[CMD_STOP];
  assign cmd_arm    = wr_cmd && reg_wdata[CMD_ARM];
  assign cmd_disarm = wr_cmd && reg_wdata[CMD_DISARM];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_ext   <= CTRL_RST[CTRL_SRC];
      cont_mode <= CTRL_RST[CTRL_CONT];
    end else if (wr_ctrl) begin
      src_ext   <= reg_wdata[CTRL_SRC];
      cont_mode <= reg_wdata[CTRL_CONT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay <= DELAY_RST;
    end else if (wr_delay) begin
      delay <= next_delay;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= frame_clk;
    end
  end

  // generator control; a halted generator waits for a fresh send
  assign gif.send       = cmd_send;
  assign gif.stop       = cmd_stop;
  assign gif.halt       = setting_chg;
  assign gif.delay      = delay;
  assign gif.bit_tick   = bit_tick;
  assign gif.frame_rise = frame_clk && !frame_q;

  bgac_gen u_gen (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .gif      (gif.gen)
  );

  // one select bit steers all three copies, so they never disagree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mod_data  <= 1'b0;
      mod_valid <= 1'b0;
    end else if (src_ext) begin
      mod_data  <= ext_bb_data;
      mod_valid <= ext_bb_valid;
    end else begin
      mod_data  <= gif.data;
      mod_valid <= gif.valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      anl_data       <= 1'b0;
      anl_data_valid <= 1'b0;
    end else if (src_ext) begin
      anl_data       <= ext_bb_data;
      anl_data_valid <= ext_bb_valid;
    end else begin
      anl_data       <= gif.data;
      anl_data_valid <= gif.valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      baseband_data_output       <= 1'b0;
      baseband_data_output_valid <= 1'b0;
    end else if (src_ext) begin
      baseband_data_output       <= ext_bb_data;
      baseband_data_output_valid <= ext_bb_valid;
    end else begin
      baseband_data_output       <= gif.data;
      baseband_data_output_valid <= gif.valid;
    end
  end

  // analyzer sequencing
  assign last_sym  = sym_valid && (sym_cnt == SYMS_M1);
  assign disarm_ok = (anl_state == BGAC_A_ARMED ||
                      anl_state == BGAC_A_MEAS) && !shown;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      anl_state <= BGAC_A_IDLE;
    end else if (cmd_arm) begin
      anl_state <= BGAC_A_ARMED;
    end else if (setting_chg && anl_state != BGAC_A_IDLE) begin
      anl_state <= BGAC_A_ARMED;
    end else if (cmd_disarm) begin
      if (disarm_ok) begin
        anl_state <= BGAC_A_IDLE;
      end
    end else begin
      case (anl_state)
        BGAC_A_ARMED: begin
          if (anl_trigger) begin
            anl_state <= BGAC_A_MEAS;
          end
        end
        BGAC_A_MEAS: begin
          if (last_sym) begin
            // continuous mode waits for the next trigger each pass
            anl_state <= cont_mode ? BGAC_A_ARMED
                                   : BGAC_A_DONE;
          end
        end
        BGAC_A_DONE: anl_state <= BGAC_A_DONE;
        default:     anl_state <= BGAC_A_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sym_cnt <= '0;
    end else if (anl_state != BGAC_A_MEAS || cmd_arm || setting_chg) begin
      sym_cnt <= '0;
    end else if (sym_valid) begin
      sym_cnt <= last_sym ? 16'h0000 : sym_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_lvl <= '0;
    end else if (anl_state == BGAC_A_MEAS && sym_valid && sym_cnt == '0) begin
      first_lvl <= sym_level;
    end
  end

  assign level_diff = $signed({1'b0, first_lvl}) - $signed({1'b0, sym_level});

  // a completion landing with arm, setting change or accepted disarm is dropped
  assign meas_end = anl_state == BGAC_A_MEAS && last_sym && !cmd_arm &&
                    !setting_chg && !(cmd_disarm && disarm_ok);

  // divide by a constant keeps the result in level units per symbol
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      droop <= '0;
    end else if (meas_end) begin
      droop <= LEVEL_W'(level_diff /
               $signed({1'b0, SYMS_M1}));
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_count <= '0;
    end else if (meas_end) begin
      meas_count <= meas_count + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_done <= 1'b0;
    end else begin
      meas_done <= meas_end;
    end
  end

  // set by the completion itself, so a disarm right after it is refused
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shown <= 1'b0;
    end else if (meas_end) begin
      shown <= 1'b1;
    end else if (cmd_arm) begin
      shown <= 1'b0;
    end
  end

  assign anl_armed = (anl_state == BGAC_A_ARMED);
  assign anl_busy  = (anl_state == BGAC_A_MEAS);

  // status word built from the named field positions
  always_comb begin
    status              = '0;
    status[ST_ARMED]    = anl_armed;
    status[ST_MEAS]     = anl_busy;
    status[ST_SHOWN]    = shown;
    status[ST_GEN_ON]   = gif.active;
    status[ST_GEN_WAIT] = gif.waiting;
    status[ST_SRC]      = src_ext;
  end

  // register read, data in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   reg_rdata <= DATA_W'({cont_mode, src_ext});
        REG_DELAY:  reg_rdata <= DATA_W'(delay);
        REG_STATUS: reg_rdata <= DATA_W'(status);
        REG_DROOP:  reg_rdata <= DATA_W'($unsigned(droop));
        REG_COUNT:  reg_rdata <= DATA_W'(meas_count);
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : bgac_top
`default_nettype wire

// *** verif/bgac_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module bgac_props #(
  parameter int MEAS_SYMS_P = bgac_pkg::MEAS_SYMS
) (
  input wire logic                        core_clk,
  input wire logic                        rst_b,
  input wire logic [bgac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bgac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        bit_tick,
  input wire logic                        ext_bb_data,
  input wire logic                        ext_bb_valid,
  input wire logic                        anl_trigger,
  input wire logic                        mod_data,
  input wire logic                        mod_valid,
  input wire logic                        anl_data,
  input wire logic                        anl_data_valid,
  input wire logic                        baseband_data_output,
  input wire logic                        baseband_data_output_valid,
  input wire logic                        anl_armed,
  input wire logic                        anl_busy,
  input wire logic                        meas_done
);
  import bgac_pkg::*;
  logic        src_q;
  logic        cont_q;
  logic        shown_q;
  logic [10:0] dly_q;
  logic [10:0] dly_new;
  logic        cmd;
  logic        chg;
  logic        send0;
  assign cmd = reg_wr && reg_addr == REG_CMD;
  // same value rewritten is no setting change
  assign dly_new = reg_wdata > 32'(DELAY_MAX) ? DELAY_MAX : reg_wdata[10:0];
  assign chg = reg_wr && (reg_addr == REG_DELAY && dly_new != dly_q
    || reg_addr == REG_CTRL && reg_wdata[1:0] != {cont_q, src_q});
  assign send0 = cmd && reg_wdata[CMD_SEND] && !reg_wdata[CMD_STOP]
    && dly_q == 11'h000 && !src_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {cont_q, src_q} <= 2'h0;
      dly_q <= 11'h000;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      {cont_q, src_q} <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == REG_DELAY) begin
      dly_q <= dly_new;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) shown_q <= 1'b0;
    else if (cmd && reg_wdata[CMD_ARM]) shown_q <= 1'b0;
    else if (meas_done) shown_q <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_copies;
    mod_valid == anl_data_valid && mod_data == anl_data
      && {mod_valid, mod_data} == {baseband_data_output_valid,
                                   baseband_data_output};
  endproperty
  a_copies: assert property (p_copies) else $error("copies differ");
  property p_ext;
    src_q && ext_bb_valid |=> mod_valid && mod_data == $past(ext_bb_data);
  endproperty
  a_ext: assert property (p_ext) else $error("external bit lost");
  property p_send0;
    send0 ##[1:4] bit_tick |-> ##2 mod_valid;
  endproperty
  a_send0: assert property (p_send0) else $error("send late");
  property p_halt;
    !src_q && (chg || cmd && reg_wdata[CMD_STOP]) |-> ##3 !mod_valid [*4];
  endproperty
  a_halt: assert property (p_halt) else $error("output kept on");
  property p_trig;
    $rose(anl_busy) |-> $past(anl_armed && anl_trigger);
  endproperty
  a_trig: assert property (p_trig) else $error("untriggered start");
  property p_single;
    meas_done && !cont_q |-> !anl_armed && !anl_busy;
  endproperty
  a_single: assert property (p_single) else $error("single rearmed");
  property p_cont;
    meas_done && cont_q |-> anl_armed;
  endproperty
  a_cont: assert property (p_cont) else $error("cont stopped");
  property p_arm;
    cmd && reg_wdata[CMD_ARM] |=> anl_armed && !anl_busy;
  endproperty
  a_arm: assert property (p_arm) else $error("arm lost");
  property p_disarm;
    cmd && reg_wdata[CMD_DISARM] && !reg_wdata[CMD_ARM] && !shown_q
      && !meas_done && (anl_armed || anl_busy) |=> !anl_armed && !anl_busy;
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm lost");
  property p_chg;
    chg && (anl_armed || anl_busy) |=> anl_armed && !anl_busy;
  endproperty
  a_chg: assert property (p_chg) else $error("no rearm");
  c_cont: cover property (meas_done && cont_q);
  c_ext: cover property (src_q && mod_valid);
  c_abort: cover property (chg && anl_busy);
endmodule : bgac_props
bind bgac_top bgac_props #(.MEAS_SYMS_P(MEAS_SYMS_P)) u_bgac_props (
  .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .bit_tick, .ext_bb_data,
  .ext_bb_valid, .anl_trigger, .mod_data, .mod_valid, .anl_data,
  .anl_data_valid, .baseband_data_output, .baseband_data_output_valid,
  .anl_armed, .anl_busy, .meas_done);
`default_nettype wire

// *** verif/bgac_radio_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bgac_radio_model (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         ext_en,
  output var  logic                         frame_clk,
  output var  logic                         bit_tick,
  output var  logic                         ext_bb_data,
  output var  logic                         ext_bb_valid,
  output var  logic [bgac_pkg::LEVEL_W-1:0] sym_level,
  output var  logic                         sym_valid
);
  import bgac_pkg::*;
  logic [4:0] cnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) cnt <= 5'h00;
    else cnt <= cnt + 5'h01;
  end
  // falling ramp: droop is one step whatever symbol comes first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) sym_level <= 16'hFF00;
    else if (sym_valid) sym_level <= sym_level - 16'h0010;
  end
  assign frame_clk = cnt[4];
  assign bit_tick = cnt[1:0] == 2'h3;
  assign sym_valid = cnt[0];
  assign ext_bb_valid = ext_en && bit_tick;
  // between bits the line toggles so stale data never looks valid
  assign ext_bb_data = ext_bb_valid ? cnt[2] ^ cnt[4] : cnt[0];
endmodule : bgac_radio_model
`default_nettype wire

// *** verif/bgac_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module bgac_top_bench;
  import bgac_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ext_en = 1'b0;
  logic        anl_trigger = 1'b0;
  logic        frame_clk, bit_tick, ext_bb_data, ext_bb_valid, sym_valid;
  logic [15:0] sym_level;
  logic        mod_data, mod_valid, anl_data, anl_data_valid, bb_d, bb_v;
  logic        anl_armed, anl_busy, meas_done;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          n;
  logic [31:0] anl_st;
  logic [31:0] copies;
  assign anl_st = {30'h0, anl_busy, anl_armed};
  assign copies = {28'h0, anl_data_valid, anl_data, bb_v, bb_d};
  always #5 core_clk = ~core_clk;
  bgac_radio_model u_bgac_radio_model (.core_clk, .rst_b, .ext_en,
    .frame_clk, .bit_tick, .ext_bb_data, .ext_bb_valid, .sym_level,
    .sym_valid);
  bgac_top #(.MEAS_SYMS_P(4)) u_bgac_top (.core_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata), .frame_clk, .bit_tick,
    .ext_bb_data, .ext_bb_valid, .anl_trigger, .sym_level, .sym_valid,
    .mod_data, .mod_valid, .anl_data, .anl_data_valid,
    .baseband_data_output(bb_d), .baseband_data_output_valid(bb_v),
    .anl_armed, .anl_busy, .meas_done);
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(s, e, rdata);
  endtask : rd
  task automatic cmd(input int b);
    wr(REG_CMD, 32'h1 << b);
  endtask : cmd
  task automatic wait_on(input bit done, output int k);
    k = 0;
    while ((done ? meas_done : mod_valid) !== 1'b1) begin
      tick();
      k++;
      if (k > 300) begin
        chk("wait", 32'h1, 32'h0);
        end_of_test();
      end
    end
  endtask : wait_on
  // skips the pipeline tail, then counts output bits
  task automatic quiet(input int cyc, output int k);
    k = 0;
    repeat (3) tick();
    repeat (cyc) begin
      tick();
      k += int'(mod_valid === 1'b1);
    end
  endtask : quiet
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    tick();
    rd(REG_CTRL, 32'h0, "ctrl");
    rd(REG_STATUS, 32'h0, "status");
    wr(REG_DELAY, 32'h7FF);
    rd(REG_DELAY, 32'h797, "delay max");
    wr(REG_STATUS, 32'h3F);
    rd(REG_STATUS, 32'h0, "status ro");
    rd(8'h20, 32'h0, "unmapped");
    wr(REG_DELAY, 32'h0);
    $display("registers done");
    cmd(CMD_SEND);
    wait_on(0, n);
    chk("send lat", 32'h1, 32'(n <= 8));
    chk("gen bit", 32'(LFSR_SEED[8]), 32'(mod_data));
    chk("copies", 32'hF, copies);
    rd(REG_STATUS, 32'h08, "sending");
    cmd(CMD_STOP);
    quiet(40, n);
    chk("stopped", 32'h0, 32'(n));
    wr(REG_DELAY, 32'd5);
    cmd(CMD_SEND);
    rd(REG_STATUS, 32'h10, "waiting");
    wait_on(0, n);
    chk("delay", 32'h1, 32'(n >= 14 && n <= 60));
    wr(REG_DELAY, 32'h0);
    quiet(40, n);
    chk("halted", 32'h0, 32'(n));
    cmd(CMD_SEND);
    wait_on(0, n);
    cmd(CMD_STOP);
    $display("generator done");
    wr(REG_CTRL, 32'h1);
    repeat (8) tick();
    ext_en <= 1'b1;
    quiet(40, n);
    chk("ext bits", 32'd10, 32'(n));
    rd(REG_STATUS, 32'h20, "ext src");
    ext_en <= 1'b0;
    wr(REG_CTRL, 32'h0);
    $display("source done");
    cmd(CMD_SEND);
    cmd(CMD_ARM);
    repeat (10) tick();
    chk("no trig", 32'h1, anl_st);
    anl_trigger <= 1'b1;
    tick();
    anl_trigger <= 1'b0;
    wait_on(1, n);
    tick();
    chk("single", 32'h0, anl_st);
    rd(REG_DROOP, 32'h10, "droop");
    rd(REG_COUNT, 32'h1, "count");
    cmd(CMD_DISARM);
    rd(REG_STATUS, 32'h0C, "shown");
    cmd(CMD_ARM);
    cmd(CMD_DISARM);
    tick();
    chk("disarm", 32'h0, anl_st);
    for (int i = 0; i < 2; i++) begin
      cmd(CMD_ARM);
      anl_trigger <= 1'b1;
      tick();
      anl_trigger <= 1'b0;
      tick();
      chk("busy", 32'h2, anl_st);
      if (i == 0) cmd(CMD_ARM);
      else wr(REG_CTRL, 32'h2);
      tick();
      chk("rearm", 32'h1, anl_st);
    end
    anl_trigger <= 1'b1;
    wait_on(1, n);
    tick();
    wait_on(1, n);
    chk("cont", 32'h1, anl_st);
    anl_trigger <= 1'b0;
    rd(REG_COUNT, 32'h3, "count cont");
    cmd(CMD_DISARM);
    tick();
    chk("kept", 32'h1, anl_st);
    $display("analyzer done");
    end_of_test();
  end
endmodule : bgac_top_bench
`default_nettype wire
